// file: drvf_top.sv
// Contract
// - Lamp steady on when stopped, unfaulted.
// - Lamp dark while drive runs.
// - Lamp blinks on fault, overriding others.
// - Input view mirrors each digital input terminal.
// - Output view shows open collector, relay coil.
// - Fault latches frequency, current, status, code.
// - Five entries: current plus four prior faults.
// - Each entry keeps its frequency, current, status.
// - Any fault removes motor power, coasting.
// - Active fault code shown on display.
// - Clear ignored while fault cause persists.
// - Auto restart only for auto-resettable faults.
// - Auto fault with restart count left above zero starts delay.
// - Delay expiry attempts automatic fault reset.
// - Cause gone: clear fault, restart drive.
//
// Purpose: Fault capture, history, coast stop, auto restart and views.
// Assumes: Fault, run and output states come from logic on CLK_I.
// Notes:   Digital input terminals are pins and are synchronised.
`default_nettype none
module drvf_top
   import drvf_pkg::*;
#(
   parameter int BLINK_CYC = BLINK_HALF_CYC,
   parameter int RETRY_CYC = RETRY_UNIT_CYC
) (
   input  wire logic              CLK_I,
   input  wire logic              RST_B_I,
   input  wire logic              RUN_I,
   input  wire logic              FAULT_REQ_I,
   input  wire logic [CODE_W-1:0] FAULT_CODE_I,
   input  wire logic              FAULT_CAUSE_I,
   input  wire logic              AUTO_OK_I,
   input  wire logic [VAL_W-1:0]  RUN_FREQ_I,
   input  wire logic [VAL_W-1:0]  CURRENT_I,
   input  wire logic [STAT_W-1:0] STATUS_I,
   input  wire logic              CLEAR_REQ_I,
   input  wire logic [CNT_W-1:0]  AUTO_RESTART_SETTING_I,
   input  wire logic [DLY_W-1:0]  RETRY_DELAY_I,
   input  wire logic [DIN_W-1:0]  DIGITAL_INPUT_TERMINALS_I,
   input  wire logic              OPEN_COLLECTOR_OUTPUT_I,
   input  wire logic              RELAY_COIL_I,
   input  wire logic [SEL_W-1:0]  HIST_SEL_I,
   output logic                   STOP_FAULT_LAMP_O,
   output logic [DIN_W-1:0]       INPUT_STATE_VIEW_O,
   output logic [1:0]             OUTPUT_STATE_VIEW_O,
   output logic                   FAULT_ACTIVE_O,
   output logic                   POWER_OFF_O,
   output logic [CODE_W-1:0]      DISPLAY_CODE_O,
   output logic                   RESTART_O,
   output logic [CNT_W-1:0]       RETRY_LEFT_O,
   output logic [CODE_W-1:0]      HIST_CODE_O,
   output logic [VAL_W-1:0]       HIST_FREQ_O,
   output logic [VAL_W-1:0]       HIST_CURR_O,
   output logic [STAT_W-1:0]      HIST_STAT_O
);
   localparam int TW = $clog2(RETRY_CYC + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(RETRY_CYC - 1);

   drvf_state_t       st_r;
   drvf_state_t       st_nxt;
   logic [DIN_W-1:0]  din_s1_r;
   logic [DIN_W-1:0]  din_s2_r;
   logic [1:0]        out_view_r;
   logic [CODE_W-1:0] hist_code_r [HIST_DEPTH];
   logic [VAL_W-1:0]  hist_freq_r [HIST_DEPTH];
   logic [VAL_W-1:0]  hist_curr_r [HIST_DEPTH];
   logic [STAT_W-1:0] hist_stat_r [HIST_DEPTH];
   logic [CNT_W-1:0]  left_r;
   logic              left_loaded_r;
   logic [DLY_W-1:0]  delay_r;
   logic [TW-1:0]     tick_r;
   logic              restart_r;
   logic [CODE_W-1:0] rd_code_r;
   logic [VAL_W-1:0]  rd_freq_r;
   logic [VAL_W-1:0]  rd_curr_r;
   logic [STAT_W-1:0] rd_stat_r;

   wire faulted   = (st_r != ST_OK);
   wire go_auto   = AUTO_OK_I && (left_r != '0);
   // A reset attempt happens once the delay has run out; a new trip
   // in the same cycle takes precedence so no event is lost.
   wire attempt   = (st_r == ST_DELAY) && (delay_r == '0) && !FAULT_REQ_I;
   wire auto_ok   = attempt && !FAULT_CAUSE_I;
   wire man_clear = faulted && CLEAR_REQ_I && !FAULT_CAUSE_I
                    && !FAULT_REQ_I;
   wire tick      = (tick_r == TICK_LAST);
   wire sel_ok    = (HIST_SEL_I < SEL_W'(HIST_DEPTH));

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_OK:    st_nxt = ST_OK;
         ST_FAULT: st_nxt = man_clear ? ST_OK : ST_FAULT;
         ST_DELAY: begin
            if (man_clear)
               st_nxt = ST_OK;
            else if (attempt)
               st_nxt = auto_ok ? ST_OK : ST_FAULT;
         end
         default:  st_nxt = ST_FAULT;
      endcase
      if (FAULT_REQ_I)
         st_nxt = go_auto ? ST_DELAY : ST_FAULT;
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         st_r          <= ST_OK;
         din_s1_r      <= '0;
         din_s2_r      <= '0;
         out_view_r    <= '0;
         left_r        <= '0;
         left_loaded_r <= 1'b0;
         delay_r       <= '0;
         tick_r        <= '0;
         restart_r     <= 1'b0;
      end else begin
         st_r          <= st_nxt;
         din_s1_r      <= DIGITAL_INPUT_TERMINALS_I;
         din_s2_r      <= din_s1_r;
         out_view_r    <= {RELAY_COIL_I, OPEN_COLLECTOR_OUTPUT_I};
         restart_r     <= auto_ok;
         left_loaded_r <= 1'b1;
         // The count is refilled only by start-up or a manual clear, so
         // a cause that keeps tripping cannot restart the drive forever.
         if (!left_loaded_r || man_clear)
            left_r <= AUTO_RESTART_SETTING_I;
         else if (attempt)
            left_r <= left_r - 1'b1;
         if (FAULT_REQ_I) begin
            delay_r <= RETRY_DELAY_I;
            tick_r  <= '0;
         end else if (st_r == ST_DELAY && delay_r != '0) begin
            tick_r  <= tick ? '0 : tick_r + 1'b1;
            if (tick)
               delay_r <= delay_r - 1'b1;
         end
      end
   end

   // History is written only on a trip; clears leave it alone.
   generate
      for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
         logic [CODE_W-1:0] src_code;
         logic [VAL_W-1:0]  src_freq;
         logic [VAL_W-1:0]  src_curr;
         logic [STAT_W-1:0] src_stat;
         // The source is chosen at elaboration, so entry 0 never names
         // a neighbour below the bottom of the array.
         if (i == 0) begin : g_new
            assign src_code = FAULT_CODE_I;
            assign src_freq = RUN_FREQ_I;
            assign src_curr = CURRENT_I;
            assign src_stat = STATUS_I;
         end else begin : g_old
            assign src_code = hist_code_r[i-1];
            assign src_freq = hist_freq_r[i-1];
            assign src_curr = hist_curr_r[i-1];
            assign src_stat = hist_stat_r[i-1];
         end
         always_ff @(posedge CLK_I or negedge RST_B_I) begin
            if (!RST_B_I) begin
               hist_code_r[i] <= '0;
               hist_freq_r[i] <= '0;
               hist_curr_r[i] <= '0;
               hist_stat_r[i] <= '0;
            end else if (FAULT_REQ_I) begin
               hist_code_r[i] <= src_code;
               hist_freq_r[i] <= src_freq;
               hist_curr_r[i] <= src_curr;
               hist_stat_r[i] <= src_stat;
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rd_code_r <= '0;
         rd_freq_r <= '0;
         rd_curr_r <= '0;
         rd_stat_r <= '0;
      end else begin
         rd_code_r <= sel_ok ? hist_code_r[HIST_SEL_I] : '0;
         rd_freq_r <= sel_ok ? hist_freq_r[HIST_SEL_I] : '0;
         rd_curr_r <= sel_ok ? hist_curr_r[HIST_SEL_I] : '0;
         rd_stat_r <= sel_ok ? hist_stat_r[HIST_SEL_I] : '0;
      end
   end

   drvf_lamp #(
      .HALF_CYC (BLINK_CYC)
   ) u_lamp (
      .clk_i    (CLK_I),
      .rst_b_i  (RST_B_I),
      .run_i    (RUN_I),
      .fault_i  (faulted),
      .lamp_o   (STOP_FAULT_LAMP_O)
   );

   assign INPUT_STATE_VIEW_O  = din_s2_r;
   assign OUTPUT_STATE_VIEW_O = out_view_r;
   assign FAULT_ACTIVE_O      = faulted;
   assign POWER_OFF_O         = faulted;
   assign DISPLAY_CODE_O      = faulted ? hist_code_r[0] : '0;
   assign RESTART_O           = restart_r;
   assign RETRY_LEFT_O        = left_r;
   assign HIST_CODE_O         = rd_code_r;
   assign HIST_FREQ_O         = rd_freq_r;
   assign HIST_CURR_O         = rd_curr_r;
   assign HIST_STAT_O         = rd_stat_r;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);

   a_input_view: assert property (##3 1 |->
      INPUT_STATE_VIEW_O == $past(DIGITAL_INPUT_TERMINALS_I, 2))
      else $error("input view does not follow terminals");
   a_output_view: assert property (##1 1 |-> OUTPUT_STATE_VIEW_O ==
      $past({RELAY_COIL_I, OPEN_COLLECTOR_OUTPUT_I}))
      else $error("output view wrong");
   a_trip_capture: assert property (FAULT_REQ_I |=>
      hist_freq_r[0] == $past(RUN_FREQ_I) &&
      hist_curr_r[0] == $past(CURRENT_I) &&
      hist_stat_r[0] == $past(STATUS_I) &&
      hist_code_r[0] == $past(FAULT_CODE_I))
      else $error("trip values not captured");
   a_hist_shift: assert property (FAULT_REQ_I |=>
      hist_code_r[4] == $past(hist_code_r[3]) &&
      hist_code_r[1] == $past(hist_code_r[0]))
      else $error("history did not shift");
   a_hist_values: assert property (FAULT_REQ_I |=>
      hist_stat_r[2] == $past(hist_stat_r[1]) &&
      hist_freq_r[3] == $past(hist_freq_r[2]))
      else $error("history values did not shift");
   a_power_off: assert property (FAULT_REQ_I |=>
      POWER_OFF_O && !RESTART_O)
      else $error("power not removed on trip");
   a_display_code: assert property (FAULT_REQ_I |=>
      DISPLAY_CODE_O == $past(FAULT_CODE_I))
      else $error("display does not show fault code");
   a_clear_blocked: assert property (faulted && FAULT_CAUSE_I
      |=> faulted)
      else $error("fault cleared while cause present");
   a_manual_only: assert property (FAULT_REQ_I && !AUTO_OK_I |=>
      st_r == ST_FAULT)
      else $error("non auto fault entered retry");
   a_delay_load: assert property (FAULT_REQ_I && go_auto |=>
      st_r == ST_DELAY && delay_r == $past(RETRY_DELAY_I))
      else $error("retry delay not started");
   a_retry_fires: assert property (st_r == ST_DELAY && delay_r == '0
      && !FAULT_REQ_I && !FAULT_CAUSE_I |=> RESTART_O && !faulted
      ##1 !RESTART_O)
      else $error("auto reset did not restart once");
   a_attempt_count: assert property (attempt && !man_clear |=>
      left_r == $past(left_r) - 1'b1)
      else $error("attempt count not decremented");
   a_hist_kept: assert property (!FAULT_REQ_I |=>
      $stable(hist_code_r[0]) && $stable(hist_stat_r[4]))
      else $error("history changed without a trip");

   c_auto_restart: cover property (RESTART_O);
   c_manual_clear: cover property (man_clear);
   c_retry_failed: cover property (attempt && FAULT_CAUSE_I);
   c_back_to_back: cover property (FAULT_REQ_I ##1 FAULT_REQ_I);
endmodule : drvf_top
`default_nettype wire

// file: drvf_pkg.sv
// Purpose: Shared constants for the drive fault, status and restart block.
// Assumes: One 10 MHz system clock.
// Notes:   Times are in nanoseconds; cycle counts derive from them.
`default_nettype none
package drvf_pkg;
   localparam int CLK_PERIOD_NS   = 100;
   localparam int BLINK_HALF_NS   = 500_000_000;
   localparam int BLINK_HALF_CYC  = BLINK_HALF_NS / CLK_PERIOD_NS;
   localparam int RETRY_UNIT_NS   = 100_000_000;
   localparam int RETRY_UNIT_CYC  = RETRY_UNIT_NS / CLK_PERIOD_NS;
   localparam int HIST_DEPTH      = 5;
   localparam int DIN_W           = 8;
   localparam int CODE_W          = 8;
   localparam int VAL_W           = 16;
   localparam int STAT_W          = 8;
   localparam int CNT_W           = 4;
   localparam int DLY_W           = 8;
   localparam int SEL_W           = 3;
   typedef enum logic [1:0] {ST_OK, ST_FAULT, ST_DELAY} drvf_state_t;
endpackage : drvf_pkg
`default_nettype wire

// file: drvf_lamp.sv
// Purpose: Stop/fault lamp driver with a free-running blink divider.
// Assumes: Run and fault levels come from logic on the same clock.
// Notes:   Lamp follows its cause one clock later.
`default_nettype none
module drvf_lamp
   import drvf_pkg::*;
#(
   parameter int HALF_CYC = BLINK_HALF_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic run_i,
   input  wire logic fault_i,
   output logic      lamp_o
);
   localparam int BW = $clog2(HALF_CYC + 1);
   localparam logic [BW-1:0] LAST = BW'(HALF_CYC - 1);

   logic [BW-1:0] blink_cnt_r;
   logic          blink_r;
   logic          lamp_r;
   wire           blink_wrap = (blink_cnt_r == LAST);
   // Fault blinking wins over both steady indications.
   wire           lamp_nxt   = fault_i ? blink_r : !run_i;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b0;
         lamp_r      <= 1'b0;
      end else begin
         blink_cnt_r <= blink_wrap ? '0 : blink_cnt_r + 1'b1;
         blink_r     <= blink_wrap ? !blink_r : blink_r;
         lamp_r      <= lamp_nxt;
      end
   end
   assign lamp_o = lamp_r;

   a_lamp_solid: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !fault_i && !run_i |=> lamp_o)
      else $error("lamp not lit while stopped");
   a_lamp_dark: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      !fault_i && run_i |=> !lamp_o)
      else $error("lamp lit while running");
   a_lamp_blink: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      fault_i |=> lamp_o == $past(blink_r))
      else $error("lamp does not follow blink on fault");
endmodule : drvf_lamp
`default_nettype wire

// file: drvf_plant.sv
// Purpose: Behavioural far side: terminal strip run command and power stage.
// Assumes: Commands change on the falling edge of the system clock.
// Notes:   The motor only turns while the drive keeps power applied.
`default_nettype none
module drvf_plant (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic run_cmd_i,
   input  wire logic power_off_i,
   output logic      run_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic run_r;
   // Removing power drops the run state at once, so a coasting motor never
   // reports running to the lamp logic.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_r <= 1'b0;
      end else begin
         run_r <= run_cmd_i && !power_off_i;
      end
   end
   assign run_o = run_r && !power_off_i;
endmodule // drvf_plant
`default_nettype wire

// file: tb_drvf_top.sv
// Purpose: Self-checking bench for the fault, status and restart block.
// Assumes: Short blink and retry counts; inputs change on falling edges.
// Notes:   Each scenario is its own task and judges its own results.
`default_nettype none
module tb_drvf_top import drvf_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BLK = 4;
   localparam int RTY = 3;
   logic clk, rst_b, run_cmd, run, freq_req, cause, auto_ok, clr, oc, relay;
   logic [7:0] code, stat, dly, term, view_in, d_code, h_code, h_stat;
   logic [15:0] freq, curr, h_freq, h_curr;
   logic [3:0] setting, left;
   logic [2:0] sel;
   logic [1:0] view_out;
   logic lamp, flt, poff, rst_o, seen;
   int errors = 0, checks_done = 0, cycles = 0, n;
   drvf_plant PLANT (.clk_i(clk), .rst_b_i(rst_b), .run_cmd_i(run_cmd),
      .power_off_i(poff), .run_o(run));
   drvf_top #(.BLINK_CYC(BLK), .RETRY_CYC(RTY)) DUT (.CLK_I(clk),
      .RST_B_I(rst_b), .RUN_I(run), .FAULT_REQ_I(freq_req),
      .FAULT_CODE_I(code), .FAULT_CAUSE_I(cause), .AUTO_OK_I(auto_ok),
      .RUN_FREQ_I(freq), .CURRENT_I(curr), .STATUS_I(stat),
      .CLEAR_REQ_I(clr), .AUTO_RESTART_SETTING_I(setting),
      .RETRY_DELAY_I(dly), .DIGITAL_INPUT_TERMINALS_I(term),
      .OPEN_COLLECTOR_OUTPUT_I(oc), .RELAY_COIL_I(relay), .HIST_SEL_I(sel),
      .STOP_FAULT_LAMP_O(lamp), .INPUT_STATE_VIEW_O(view_in),
      .OUTPUT_STATE_VIEW_O(view_out), .FAULT_ACTIVE_O(flt),
      .POWER_OFF_O(poff), .DISPLAY_CODE_O(d_code), .RESTART_O(rst_o),
      .RETRY_LEFT_O(left), .HIST_CODE_O(h_code), .HIST_FREQ_O(h_freq),
      .HIST_CURR_O(h_curr), .HIST_STAT_O(h_stat));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input string nm, input logic [15:0] s, e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Trip fields are derived from the code so each entry is distinguishable.
   task automatic load(input logic [7:0] c, input logic a,
                       input logic [7:0] d);
      code = c;
      auto_ok = a;
      dly = d;
      stat = ~c;
      freq = {8'h10, c};
      curr = {8'h20, c};
      freq_req = 1'b1;
   endtask
   task automatic trip(input logic [7:0] c, input logic a,
                       input logic [7:0] d);
      load(c, a, d);
      cyc(1);
      freq_req = 1'b0;
   endtask
   task automatic t_lamp();
      check("lamp stopped", lamp, 1);
      run_cmd = 1'b1;
      cyc(3);
      check("lamp running", lamp, 0);
   endtask
   task automatic t_views();
      foreach (term[i]) begin
         term = 8'h01 << i;
         oc = i[0];
         relay = ~i[0];
         cyc(4);
         check("input view", view_in, 8'h01 << i);
         check("output view", view_out, {~i[0], i[0]});
      end
   endtask
   // Six back-to-back trips: entry 0 newest, oldest pushed out.
   task automatic t_hist();
      cause = 1'b1;
      for (int i = 1; i <= 6; i++) begin
         load(i[7:0], 1'b0, 8'h00);
         cyc(1);
      end
      freq_req = 1'b0;
      check("fault active", flt, 1);
      check("power off", poff, 1);
      check("display", d_code, 8'h06);
      cyc(2);
      n = 0;
      repeat (16) begin
         cyc(1);
         n += lamp;
      end
      check("blink highs", n[15:0], BLK * 2);
      for (int s = 0; s <= 5; s++) begin
         sel = s[2:0];
         cyc(2);
         code = (s < 5) ? 8'(6 - s) : 8'h00;
         check("hist code", h_code, code);
         check("hist freq", h_freq, (s < 5) ? {8'h10, code} : 16'h0);
         check("hist curr", h_curr, (s < 5) ? {8'h20, code} : 16'h0);
         check("hist stat", h_stat, (s < 5) ? 8'(~code) : 8'h00);
      end
   endtask
   task automatic clear_try(input logic c);
      cause = c;
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(1);
   endtask
   task automatic t_clear();
      clear_try(1'b1);
      check("clear refused", flt, 1);
      clear_try(1'b0);
      check("clear taken", flt, 0);
      check("display idle", d_code, 8'h00);
      check("count reload", left, setting);
      sel = 3'd0;
      cyc(2);
      check("hist kept", h_code, 8'h06);
   endtask
   task automatic wait_restart(input int lim);
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++) begin
         cyc(1);
         seen = (rst_o === 1'b1);
      end
   endtask
   task automatic t_auto();
      trip(8'h21, 1'b1, 8'h01);
      check("delay faulted", flt, 1);
      wait_restart(RTY + 6);
      check("restart pulse", seen, 1);
      check("auto cleared", flt, 0);
      check("count dec", left, 4'd1);
      cyc(1);
      check("pulse width", rst_o, 0);
      cyc(3);
      check("running again", lamp, 0);
      cause = 1'b1;
      trip(8'h22, 1'b1, 8'h00);
      wait_restart(8);
      check("cause stays", flt | seen, 1);
      check("no restart", seen, 0);
      check("count zero", left, 4'd0);
      // With the count spent, even a vanished cause must not restart.
      cause = 1'b0;
      trip(8'h24, 1'b1, 8'h00);
      wait_restart(8);
      check("count spent", {seen, flt}, 2'b01);
      check("count held", left, 4'd0);
      clear_try(1'b0);
      trip(8'h23, 1'b0, 8'h00);
      wait_restart(RTY * 4);
      check("manual only", {seen, flt}, 2'b01);
      setting = 4'd0;
      clear_try(1'b0);
      check("final clear", flt, 0);
      check("zero reload", left, 4'd0);
      trip(8'h25, 1'b1, 8'h00);
      wait_restart(8);
      check("setting zero", {seen, flt}, 2'b01);
      clear_try(1'b0);
      check("zero cleared", flt, 0);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      rst_b = 1'b0;
      run_cmd = 1'b0;
      freq_req = 1'b0;
      cause = 1'b0;
      auto_ok = 1'b0;
      clr = 1'b0;
      oc = 1'b0;
      relay = 1'b0;
      code = 8'h00;
      stat = 8'h00;
      dly = 8'h00;
      term = 8'h00;
      freq = 16'h0;
      curr = 16'h0;
      setting = 4'd2;
      sel = 3'd0;
      cyc(16);
      rst_b = 1'b1;
      cyc(3);
      t_lamp();
      t_views();
      t_hist();
      t_clear();
      t_auto();
      summarize();
   end
endmodule // tb_drvf_top
`default_nettype wire
